/* logic/ebps_ready_sampler.sv */
/*
 * Ready pin sampler: synchronises the ready pin and the bus reference
 * clock pin, takes the synchronous sample on each bus clock rising edge
 * or passes the value through one more stage in asynchronous mode.
 * Assumes both pins come from outside the clock domain.
 */
`timescale 1ns/1ns
`default_nettype none

module ebps_ready_sampler (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic ready_pin_i,
	input  wire logic bus_clk_pin_i,
	input  wire logic pol_i,
	input  wire logic async_i,
	output var  logic ready_ok_o
);

	typedef struct packed {
		logic rdy_meta;
		logic rdy_sync;
		logic rdy_extra;
		logic clk_meta;
		logic clk_sync;
		logic clk_prev;
		logic rdy_edge_smp;
		logic ok;
	} ebps_rs_state_t;

	ebps_rs_state_t s_reg;
	ebps_rs_state_t s_next;
	logic           level;

	////////////////////////////////////////////////////////////////////////
	// next state: two-stage synchronisers, edge sample, extra stage
	always_comb begin
		s_next          = s_reg;
		s_next.rdy_meta = ready_pin_i;
		s_next.rdy_sync = s_reg.rdy_meta;
		s_next.clk_meta = bus_clk_pin_i;
		s_next.clk_sync = s_reg.clk_meta;
		s_next.clk_prev = s_reg.clk_sync;
		s_next.rdy_extra = s_reg.rdy_sync; // R11
		// sample taken at each rising edge of the bus reference clock
		if (s_reg.clk_sync && !s_reg.clk_prev) begin // R10
			s_next.rdy_edge_smp = s_reg.rdy_sync;
		end
		level     = async_i ? s_reg.rdy_extra : s_reg.rdy_edge_smp; // R11
		s_next.ok = (pol_i == ebps_pkg::READY_ACTIVE_HIGH) ? level : ~level; // R9
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign ready_ok_o = s_reg.ok;

	// async path: ok follows the extra stage one cycle later
	chk_async_stage: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R11
		async_i && $stable(async_i) && $stable(pol_i)
		|=> ready_ok_o == ($past(pol_i) ? $past(s_reg.rdy_extra) : ~$past(s_reg.rdy_extra)))
		else $error("async ready not taken from extra stage");

endmodule : ebps_ready_sampler

`default_nettype wire

/* logic/ebps_sequencer.sv */
/*
 * External bus phase sequencer: runs each bus cycle through address setup,
 * command delay, data setup/tristate, access and hold, each counted in cpu
 * clock periods from the chip-select timing configuration, with optional
 * ready-controlled stretching of the access phase.
 * Assumes START_I and CFG_I come from logic on REF_CLK_I (50 MHz), and the
 * ready and bus reference clock pins come from outside.
 */
// Functional notes
// [R1] every bus cycle runs address setup, command, data, access, hold in order
// [R2] phase lengths come from the chip-select timing config; command delay zero to three
// [R3] with ready enabled the external module stretches access until ready is active
// [R4] address setup lasts one or two periods as configured
// [R5] a changed address window adds zero to three extra setup periods, five at most
// [R6] data setup/tristate phase lasts zero or one period
// [R7] access phase lasts one to thirty-two periods before ready waits
// [R8] hold phase lasts zero to three periods
// [R9] active level of the ready input is selectable
// [R10] synchronous ready is sampled on bus reference clock edges without extra stage
// [R11] asynchronous ready passes one extra stage, adding at least one wait
// [R12] ready inactive at sample inserts a wait; ready active ends the cycle
// [R13] a phase of zero length is skipped to the next phase
`timescale 1ns/1ns
`default_nettype none

module ebps_sequencer #(
	parameter int unsigned WIN_W = ebps_pkg::WIN_W
) (
	input  wire logic                  REF_CLK_I,
	input  wire logic                  RST_B_I,
	input  wire logic                  START_I,
	input  wire ebps_pkg::ebps_cfg_t   CFG_I,
	input  wire logic [WIN_W-1:0]      WINDOW_I,
	input  wire logic                  READY_PIN_I,
	input  wire logic                  BUS_REF_CLK_I,
	output var  logic                  BUSY_O,
	output var  ebps_pkg::ebps_phase_t PHASE_O,
	output var  logic                  DONE_O,
	output var  logic                  WAIT_STATE_O
);

	typedef struct packed {
		ebps_pkg::ebps_phase_t             phase;
		logic [ebps_pkg::CNT_W-1:0]        cnt;
		ebps_pkg::ebps_cfg_t               cfg;
		logic [WIN_W-1:0]                  last_win;
		logic                              win_valid;
		logic                              win_chg;
		logic                              done;
		logic                              waiting;
		logic                              busy;
	} ebps_seq_state_t;

	ebps_seq_state_t st_reg;
	ebps_seq_state_t st_next;
	logic            ready_ok;
	logic            access_end;
	logic            last_cycle;

	////////////////////////////////////////////////////////////////////////
	// functions

	// length of a phase in cpu clock periods
	function automatic logic [ebps_pkg::CNT_W-1:0] phase_len(
		input ebps_pkg::ebps_phase_t p,
		input ebps_pkg::ebps_cfg_t   c,
		input logic                  chg
	);
		logic [ebps_pkg::CNT_W-1:0] len;
		len = '0;
		case (p)
			ebps_pkg::EBPS_ADDR: begin
				len = ebps_pkg::ADDR_BASE_LEN + {5'h00, c.addr_setup}
					+ (chg ? {4'h0, c.addr_extra} : 6'h00); // R4 R5
			end
			ebps_pkg::EBPS_CMD:    len = {4'h0, c.cmd_delay};                         // R2
			ebps_pkg::EBPS_DATA:   len = {5'h00, c.data_setup};                       // R6
			ebps_pkg::EBPS_ACCESS: len = ebps_pkg::ACCESS_BASE_LEN + {1'b0, c.access}; // R7
			ebps_pkg::EBPS_HOLD:   len = {4'h0, c.hold};                              // R8
			default:               len = '0;
		endcase
		return len;
	endfunction : phase_len

	// next phase of nonzero length after p, idle after the last
	function automatic ebps_pkg::ebps_phase_t next_phase(
		input ebps_pkg::ebps_phase_t p,
		input ebps_pkg::ebps_cfg_t   c
	);
		ebps_pkg::ebps_phase_t n;
		n = ebps_pkg::EBPS_IDLE;
		case (p)
			ebps_pkg::EBPS_IDLE: n = ebps_pkg::EBPS_ADDR; // R1
			ebps_pkg::EBPS_ADDR: begin
				if (c.cmd_delay != 2'h0) n = ebps_pkg::EBPS_CMD;   // R1
				else if (c.data_setup) n = ebps_pkg::EBPS_DATA;    // R13
				else n = ebps_pkg::EBPS_ACCESS;                     // R13
			end
			ebps_pkg::EBPS_CMD: begin
				if (c.data_setup) n = ebps_pkg::EBPS_DATA; // R1
				else n = ebps_pkg::EBPS_ACCESS;            // R13
			end
			ebps_pkg::EBPS_DATA: n = ebps_pkg::EBPS_ACCESS; // R1
			ebps_pkg::EBPS_ACCESS: begin
				if (c.hold != 2'h0) n = ebps_pkg::EBPS_HOLD; // R1
				else n = ebps_pkg::EBPS_IDLE;                // R13
			end
			default: n = ebps_pkg::EBPS_IDLE;
		endcase
		return n;
	endfunction : next_phase

	////////////////////////////////////////////////////////////////////////
	// ready pin sampling
	ebps_ready_sampler u_ready (
		.clk_i         (REF_CLK_I),
		.rst_b_i       (RST_B_I),
		.ready_pin_i   (READY_PIN_I),
		.bus_clk_pin_i (BUS_REF_CLK_I),
		.pol_i         (st_reg.cfg.ready_pol),
		.async_i       (st_reg.cfg.ready_async),
		.ready_ok_o    (ready_ok)
	);

	////////////////////////////////////////////////////////////////////////
	// phase sequencing
	always_comb begin
		st_next         = st_reg;
		st_next.done    = 1'b0;
		st_next.waiting = 1'b0;
		last_cycle      = (st_reg.cnt == ebps_pkg::LAST_COUNT);
		access_end      = !st_reg.cfg.ready_en || ready_ok; // R3 R12
		case (st_reg.phase)
			ebps_pkg::EBPS_IDLE: begin
				// a new cycle latches its configuration and window
				if (START_I) begin
					st_next.cfg       = CFG_I; // R2
					st_next.win_chg   = !st_reg.win_valid || (WINDOW_I != st_reg.last_win); // R5
					st_next.last_win  = WINDOW_I;
					st_next.win_valid = 1'b1;
					st_next.phase     = ebps_pkg::EBPS_ADDR; // R1
					st_next.cnt       = phase_len(ebps_pkg::EBPS_ADDR, CFG_I,
						!st_reg.win_valid || (WINDOW_I != st_reg.last_win));
				end
			end
			ebps_pkg::EBPS_ADDR,
			ebps_pkg::EBPS_CMD,
			ebps_pkg::EBPS_DATA,
			ebps_pkg::EBPS_HOLD: begin
				if (!last_cycle) begin
					st_next.cnt = st_reg.cnt - ebps_pkg::LAST_COUNT;
				end else begin
					st_next.phase = next_phase(st_reg.phase, st_reg.cfg); // R1 R13
					st_next.cnt   = phase_len(next_phase(st_reg.phase, st_reg.cfg), st_reg.cfg, st_reg.win_chg);
					st_next.done  = (next_phase(st_reg.phase, st_reg.cfg) == ebps_pkg::EBPS_IDLE);
				end
			end
			ebps_pkg::EBPS_ACCESS: begin
				if (!last_cycle) begin
					st_next.cnt = st_reg.cnt - ebps_pkg::LAST_COUNT; // R7
				end else if (!access_end) begin
					st_next.waiting = 1'b1; // R3 R12
				end else begin
					st_next.phase = next_phase(st_reg.phase, st_reg.cfg); // R12 R13
					st_next.cnt   = phase_len(next_phase(st_reg.phase, st_reg.cfg), st_reg.cfg, st_reg.win_chg);
					st_next.done  = (next_phase(st_reg.phase, st_reg.cfg) == ebps_pkg::EBPS_IDLE);
				end
			end
			default: begin
				st_next.phase = ebps_pkg::EBPS_IDLE;
				st_next.cnt   = '0;
			end
		endcase
		// busy is kept in a flip-flop so the output needs no decode
		st_next.busy = (st_next.phase != ebps_pkg::EBPS_IDLE);
	end

	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			st_reg       <= '0;
			st_reg.phase <= ebps_pkg::EBPS_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, straight from the state flip-flops
	assign PHASE_O      = st_reg.phase;
	assign BUSY_O       = st_reg.busy;
	assign DONE_O       = st_reg.done;
	assign WAIT_STATE_O = st_reg.waiting;

	////////////////////////////////////////////////////////////////////////
	// checks
	chk_start_addr: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R1
		st_reg.phase == ebps_pkg::EBPS_IDLE && START_I |=> st_reg.phase == ebps_pkg::EBPS_ADDR)
		else $error("cycle did not open with address setup");

	chk_addr_next: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R1
		st_reg.phase == ebps_pkg::EBPS_ADDR && st_reg.cnt == 6'h01
		|=> st_reg.phase inside {ebps_pkg::EBPS_CMD, ebps_pkg::EBPS_DATA, ebps_pkg::EBPS_ACCESS})
		else $error("address setup left out of order");

	chk_addr_length: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R4 R5
		$changed(st_reg.phase) && st_reg.phase == ebps_pkg::EBPS_ADDR
		|-> st_reg.cnt == 6'h01 + st_reg.cfg.addr_setup + (st_reg.win_chg ? st_reg.cfg.addr_extra : 2'h0))
		else $error("address setup length wrong");

	chk_cmd_length: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R2
		$changed(st_reg.phase) && st_reg.phase == ebps_pkg::EBPS_CMD |-> st_reg.cnt == {4'h0, st_reg.cfg.cmd_delay})
		else $error("command delay length wrong");

	chk_data_length: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R6
		$changed(st_reg.phase) && st_reg.phase == ebps_pkg::EBPS_DATA |-> st_reg.cfg.data_setup && st_reg.cnt == 6'h01)
		else $error("data setup entered wrongly");

	chk_access_length: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R7
		$changed(st_reg.phase) && st_reg.phase == ebps_pkg::EBPS_ACCESS |-> st_reg.cnt == st_reg.cfg.access + 6'h01)
		else $error("access length wrong");

	chk_hold_length: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R8
		$changed(st_reg.phase) && st_reg.phase == ebps_pkg::EBPS_HOLD |-> st_reg.cnt == {4'h0, st_reg.cfg.hold})
		else $error("hold length wrong");

	chk_ready_wait: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R3 R12
		st_reg.phase == ebps_pkg::EBPS_ACCESS && st_reg.cnt == 6'h01 && st_reg.cfg.ready_en && !ready_ok
		|=> st_reg.phase == ebps_pkg::EBPS_ACCESS && WAIT_STATE_O)
		else $error("ready inactive did not insert a wait");

	chk_skip_hold: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R13 R12
		st_reg.phase == ebps_pkg::EBPS_ACCESS && st_reg.cnt == 6'h01 && (!st_reg.cfg.ready_en || ready_ok)
		&& st_reg.cfg.hold == 2'h0 |=> st_reg.phase == ebps_pkg::EBPS_IDLE && DONE_O)
		else $error("zero hold not skipped");

endmodule : ebps_sequencer

`default_nettype wire

/* shared/ebps_pkg.sv */
/*
 * Package of the external bus phase sequencer: chip-select timing
 * configuration, phase encodings and the base lengths of the address setup and access phases.
 * Assumes a single cpu clock; one cpu_clock_period is one clock cycle.
 */
package ebps_pkg;

	////////////////////////////////////////////////////////////////////////
	// widths
	localparam int unsigned CNT_W = 6;   // phase counter, holds up to 32
	localparam int unsigned WIN_W = 4;   // address window identifier

	////////////////////////////////////////////////////////////////////////
	// base lengths in cpu clock periods
	localparam logic [CNT_W-1:0] ADDR_BASE_LEN   = 6'h01; // setup field 0 -> 1, 1 -> 2
	localparam logic [CNT_W-1:0] ACCESS_BASE_LEN = 6'h01; // access field 0 -> 1 ... 31 -> 32
	localparam logic [CNT_W-1:0] LAST_COUNT      = 6'h01; // counter value of a phase's last cycle

	////////////////////////////////////////////////////////////////////////
	// ready polarity codes
	localparam logic READY_ACTIVE_HIGH = 1'b1;
	localparam logic READY_ACTIVE_LOW  = 1'b0;

	// bus cycle phases, one-hot
	typedef enum logic [5:0] {
		EBPS_IDLE   = 6'h01,
		EBPS_ADDR   = 6'h02, // address_setup_phase
		EBPS_CMD    = 6'h04, // command_delay_phase
		EBPS_DATA   = 6'h08, // data_setup_tristate_phase
		EBPS_ACCESS = 6'h10, // access_phase
		EBPS_HOLD   = 6'h20  // hold_phase
	} ebps_phase_t;

	// chip_select_timing_config
	typedef struct packed {
		logic       addr_setup;   // 0: one period, 1: two periods
		logic [1:0] addr_extra;   // extra periods on a window change
		logic [1:0] cmd_delay;    // zero to three periods
		logic       data_setup;   // zero or one period
		logic [4:0] access;       // value plus one periods
		logic [1:0] hold;         // zero to three periods
		logic       ready_en;     // access phase stretched by ready
		logic       ready_pol;    // active level of the ready pin
		logic       ready_async;  // extra synchroniser stage on ready
	} ebps_cfg_t;

endpackage : ebps_pkg

/* test/ebps_ready_model.sv */
/*
 * Model of the external module behind the ready pin: raises ready a set
 * number of bus clock edges into the access phase.
 * Assumes the bus reference clock runs free and the bench says when access runs.
 */
`timescale 1ns/1ns
`default_nettype none

module ebps_ready_model (
	input  wire logic        bus_clk_i,
	input  wire logic        access_i,
	input  wire logic        pol_i,
	input  wire logic [31:0] delay_i,
	output var  logic        ready_o
);
	int unsigned cnt;

	////////////////////////////////////////////////////////////////////////
	// ready changes only on bus clock rising edges, inactive outside access
	initial begin
		cnt = 0;
		ready_o = 1'b0;
	end
	always @(posedge bus_clk_i) begin
		if (!access_i) begin
			cnt <= 0;
			ready_o <= ~pol_i;
		end else if (cnt >= delay_i) begin
			ready_o <= pol_i;
		end else begin
			cnt <= cnt + 1;
			ready_o <= ~pol_i;
		end
	end
endmodule : ebps_ready_model

`default_nettype wire

/* test/tb_top.sv */
/*
 * Self-checking bench of the bus phase sequencer: runs bus cycles with
 * several timing configurations and counts cycles spent in each phase.
 * Assumes the ready model drives the ready pin from the bus reference clock.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
	$display("FAIL %s expected %0d seen %0d", what, exp, got); end end

module tb_top;
	logic                  ref_clk, rst_b, start, ready_pin, bus_clk, busy, done, wait_st;
	logic [3:0]            win;
	ebps_pkg::ebps_cfg_t   cfg;
	ebps_pkg::ebps_phase_t phase;
	int                    failures, cmp_count, cyc, waits;
	int unsigned           model_delay;
	int                    n[5];

	ebps_sequencer uut (.REF_CLK_I(ref_clk), .RST_B_I(rst_b), .START_I(start), .CFG_I(cfg),
		.WINDOW_I(win), .READY_PIN_I(ready_pin), .BUS_REF_CLK_I(bus_clk), .BUSY_O(busy),
		.PHASE_O(phase), .DONE_O(done), .WAIT_STATE_O(wait_st));
	ebps_ready_model partner (.bus_clk_i(bus_clk), .access_i(phase === ebps_pkg::EBPS_ACCESS),
		.pol_i(cfg.ready_pol), .delay_i(model_delay), .ready_o(ready_pin));

	////////////////////////////////////////////////////////////////////////
	// cpu clock 20 ns, bus reference clock 160 ns with unrelated phase
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		bus_clk = 1'b0;
		#7;
		forever #80 bus_clk = ~bus_clk;
	end

	// cycle ceiling cuts a hang short
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one bus cycle; counts cycles per phase and checks their order
	task automatic run(input ebps_pkg::ebps_cfg_t c, input logic [3:0] w);
		int          guard, idx, last;
		logic [5:0]  pv;
		@(posedge ref_clk);
		cfg <= c;
		win <= w;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		n = '{default:0};
		waits = 0;
		last = 0;
		guard = 0;
		#1;
		while (phase !== ebps_pkg::EBPS_IDLE && guard < 2000) begin
			pv = phase;
			idx = 0;
			for (int i = 1; i < 6; i++) if (pv[i]) idx = i - 1;
			`CHK("phase order", 1'b1, idx >= last)
			last = idx;
			n[idx]++;
			waits += int'(wait_st === 1'b1);
			@(posedge ref_clk);
			#1;
			guard++;
		end
		`CHK("done pulse", 1'b1, done === 1'b1 && busy === 1'b0)
		@(posedge ref_clk);
		#1;
		`CHK("done one cycle", 1'b0, done)
	endtask : run

	// compares the phase lengths of the last run
	task automatic chk_lens(input int a, input int b, input int c, input int d, input int e);
		int exp[5];
		exp = '{a, b, c, d, e};
		for (int i = 0; i < 5; i++) `CHK("phase length", exp[i], n[i])
	endtask : chk_lens

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic s_lengths();
		run('{1'b0, 2'h0, 2'h1, 1'b0, 5'h01, 2'h1, 1'b0, 1'b1, 1'b0}, 4'h3);
		chk_lens(1, 1, 0, 2, 1);
		run('{1'b1, 2'h3, 2'h3, 1'b1, 5'h1f, 2'h3, 1'b0, 1'b1, 1'b0}, 4'h5);
		chk_lens(5, 3, 1, 32, 3);
		run('{1'b1, 2'h3, 2'h2, 1'b1, 5'h1f, 2'h2, 1'b0, 1'b1, 1'b0}, 4'h5);
		chk_lens(2, 2, 1, 32, 2);
		run('{1'b0, 2'h2, 2'h0, 1'b0, 5'h00, 2'h0, 1'b0, 1'b1, 1'b0}, 4'ha);
		chk_lens(3, 0, 0, 1, 0);
		`CHK("no waits without ready", 0, waits)
	endtask : s_lengths

	task automatic s_ready_sync();
		model_delay = 2;
		// two bus clock periods idle so ready is inactive before the access
		repeat (16) @(posedge ref_clk);
		run('{1'b0, 2'h0, 2'h0, 1'b0, 5'h00, 2'h0, 1'b1, 1'b1, 1'b0}, 4'ha);
		`CHK("sync waits inserted", 1'b1, waits >= 8 && waits <= 48)
		`CHK("access equals base plus waits", 1 + waits, n[3])
		repeat (16) @(posedge ref_clk);
	endtask : s_ready_sync

	task automatic s_ready_async_low();
		model_delay = 0;
		// new polarity first, so the pin settles to its inactive level
		cfg <= '{1'b0, 2'h0, 2'h1, 1'b1, 5'h02, 2'h1, 1'b1, 1'b0, 1'b1};
		repeat (16) @(posedge ref_clk);
		run('{1'b0, 2'h0, 2'h1, 1'b1, 5'h02, 2'h1, 1'b1, 1'b0, 1'b1}, 4'ha);
		`CHK("async adds a wait", 1'b1, waits >= 1 && waits <= 16)
		`CHK("async access length", 3 + waits, n[3])
		chk_lens(1, 1, 1, 3 + waits, 1);
		repeat (16) @(posedge ref_clk);
	endtask : s_ready_async_low

	////////////////////////////////////////////////////////////////////////
	// verdict
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	// reset, then the scenarios in turn
	initial begin
		rst_b = 1'b0;
		start = 1'b0;
		cfg = '0;
		win = 4'h0;
		model_delay = 0;
		failures = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		#1;
		`CHK("idle after reset", 1'b1, phase === ebps_pkg::EBPS_IDLE && busy === 1'b0)
		s_lengths();
		s_ready_sync();
		s_ready_async_low();
		tally_and_finish();
	end
endmodule : tb_top

`default_nettype wire
